// *** sfpw_map.svh ***
/*
  Constants of the serial flash program, erase and wrap sequencer:
  opcodes, bit counts, field positions, reset values and cycle times.
  Assumes it is included by bare name; holds definitions only.
*/
`ifndef SFPW_MAP_SVH
`define SFPW_MAP_SVH

// ----------------------------------------------------------------
// clock and self-timed cycle times
// ----------------------------------------------------------------
`define SFPW_MCLK_MHZ    50
`define SFPW_US_PER_MS   1000
`define SFPW_T_PAGE_US   400
`define SFPW_T_SECT_MS   50
`define SFPW_T_HBLK_MS   150
`define SFPW_T_BLK_MS    250

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define SFPW_OP_WRAP     8'h77
`define SFPW_OP_PAGE     8'h02
`define SFPW_OP_QPAGE    8'h32
`define SFPW_OP_SECT     8'h20
`define SFPW_OP_HBLK     8'h52
`define SFPW_OP_BLK      8'hD8
`define SFPW_OP_UNLOCK   8'h06
`define SFPW_OP_LOCK     8'h04
`define SFPW_OP_STAT1    8'h05
`define SFPW_OP_STAT2    8'h35
`define SFPW_OP_QREAD    8'hEB

// ----------------------------------------------------------------
// frame bit counts (quad lanes add four per clock)
// ----------------------------------------------------------------
`define SFPW_CMD_BITS    6'h08
`define SFPW_ADDR_END    6'h20
`define SFPW_WRAP_END    6'h28
`define SFPW_QRD_DATA    6'h38

// ----------------------------------------------------------------
// wrap setting byte, erase sizes, guard decode
// ----------------------------------------------------------------
`define SFPW_WRAP_DIS    4
`define SFPW_WRAP_SEL    6:5
`define SFPW_WRAP_RST    8'h10
`define SFPW_SECT_BITS   12
`define SFPW_HBLK_BITS   15
`define SFPW_BLK_BITS    16
`define SFPW_GUARD_FULL  5'h09
`define SFPW_ERASED      8'hFF
`define SFPW_LAST_COL    8'hFF
`define SFPW_OE_ALL_OFF  4'hF
`define SFPW_OE_SO_ONLY  4'hD

`endif

// *** sfpw_pkg.sv ***
/*
  Types of the serial flash sequencer: pin bundle, array request,
  internal cycle states. Assumes the map header for the numbers.
*/
package sfpw_pkg;

  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] io;
  } sfpw_pin_t;

  // byte requests AND into the array, the others fill with ones
  typedef enum logic [1:0] {
    SFPW_SZ_BYTE = 2'h0,
    SFPW_SZ_4K   = 2'h1,
    SFPW_SZ_32K  = 2'h2,
    SFPW_SZ_64K  = 2'h3
  } sfpw_size_t;

  typedef struct packed {
    sfpw_size_t  size;
    logic [23:0] addr;
    logic [7:0]  data;
  } sfpw_arr_req_t;

  typedef enum logic [1:0] {
    SFPW_C_IDLE = 2'h0,
    SFPW_C_SCAN = 2'h1,
    SFPW_C_WAIT = 2'h3
  } sfpw_cyc_t;

endpackage

// *** sfpw_sync.sv ***
/*
  Two-flop synchroniser for the link pins.
  Assumes the inputs are asynchronous to mclk.
*/
`timescale 1ns/1ns
module sfpw_sync #(
  parameter int          W   = 6,
  parameter logic [5:0]  RST = 6'h20
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  // meta_ff feeds q and nothing else
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      meta_ff <= RST[W-1:0];
      q       <= RST[W-1:0];
    end
    else
    begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule // sfpw_sync

// *** sfpw_fifo.sv ***
/*
  Small FIFO with a registered output stage, valid and ready both
  sides. Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module sfpw_fifo #(
  parameter int W = 34,
  parameter int D = 4
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data,
  output logic              idle
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem [D];
  logic [PW-1:0] wp_ff;
  logic [PW-1:0] rp_ff;
  logic [CW-1:0] cnt_ff;
  wire logic     push = in_valid & in_ready;
  wire logic     pop  = (cnt_ff != '0) & (~out_valid | out_ready);

  assign in_ready = (cnt_ff != CW'(D));
  assign idle     = (cnt_ff == '0) & ~out_valid;

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wp_ff] <= in_data;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wp_ff     <= '0;
      rp_ff     <= '0;
      cnt_ff    <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else
    begin
      if (push)
        wp_ff <= PW'(wp_ff + 1'b1);
      if (pop)
      begin
        rp_ff    <= PW'(rp_ff + 1'b1);
        out_data <= mem[rp_ff];
      end
      cnt_ff <= CW'(cnt_ff + CW'(push) - CW'(pop));
      if (pop)
        out_valid <= 1'b1;
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end
endmodule // sfpw_fifo

// *** sfpw_core.sv ***
/*
  Command sequencer of a serial NOR flash: wrap setting, single and
  quad page program, sector and block erase, status and quad read.
  Assumes the pins arrive asynchronously, the array sits behind the
  request port and read port, and status bits come from outside.
*/
`timescale 1ns/1ns
`include "sfpw_map.svh"
module sfpw_core #(
  parameter int unsigned PAGE_CYC = `SFPW_T_PAGE_US * `SFPW_MCLK_MHZ,
  parameter int unsigned SECT_CYC =
    `SFPW_T_SECT_MS * `SFPW_US_PER_MS * `SFPW_MCLK_MHZ,
  parameter int unsigned HBLK_CYC =
    `SFPW_T_HBLK_MS * `SFPW_US_PER_MS * `SFPW_MCLK_MHZ,
  parameter int unsigned BLK_CYC  =
    `SFPW_T_BLK_MS * `SFPW_US_PER_MS * `SFPW_MCLK_MHZ
) (
  input  wire logic                   mclk,
  input  wire logic                   srst,
  input  wire sfpw_pkg::sfpw_pin_t    pin_i,
  output logic [3:0]                  io_out,
  output logic [3:0]                  io_oe_n,
  input  wire logic                   quad_io_enable,
  input  wire logic [4:0]             region_guard_bits,
  output logic                        cycle_busy_flag,
  output logic                        write_latch_flag,
  output logic [7:0]                  wrap_cfg,
  output logic [23:0]                 mem_rd_addr,
  input  wire logic [7:0]             mem_rd_data,
  output logic                        arr_valid,
  input  wire logic                   arr_ready,
  output sfpw_pkg::sfpw_arr_req_t     arr_req
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic guarded(input logic [23:0] a,
                                   input logic [4:0]  g);
    logic [8:0] lim;
    lim = 9'h100 - 9'(9'h001 << (g - 5'h01));
    if (g == 5'h00)
      return 1'b0;
    if (g > `SFPW_GUARD_FULL)
      return 1'b1;
    return {1'b0, a[23:16]} >= lim;
  endfunction

  function automatic logic [23:0] next_rd(input logic [23:0] a,
                                          input logic [7:0]  w);
    logic [7:0] m;
    m = 8'(8'h08 << w[`SFPW_WRAP_SEL]) - 8'h01;
    if (w[`SFPW_WRAP_DIS])
      return 24'(a + 24'h000001);
    return {a[23:8], (a[7:0] & ~m) | (8'(a[7:0] + 8'h01) & m)};
  endfunction

  // ----------------------------------------------------------------
  // pin sampling and edges
  // ----------------------------------------------------------------
  sfpw_pkg::sfpw_pin_t pin_s;
  logic                sclk_d_ff;
  logic                sel_d_ff;

  sfpw_sync #(.W(6), .RST(6'h20)) u_sync (
    .mclk (mclk),
    .srst (srst),
    .d    (pin_i),
    .q    (pin_s)
  );

  wire logic sel      = ~pin_s.cs_n;
  wire logic cs_fall  = sel & ~sel_d_ff;
  wire logic cs_rise  = ~sel & sel_d_ff;
  wire logic bit_rise = sel & pin_s.sclk & ~sclk_d_ff;
  wire logic bit_fall = sel & ~pin_s.sclk & sclk_d_ff;

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  logic [7:0]  cmd_ff;
  logic [5:0]  cnt_ff;
  logic [23:0] sh_ff;
  logic [23:0] addr_ff;
  logic [2:0]  dcnt_ff;
  logic [7:0]  col_ff;
  logic        any_ff;
  logic [2:0]  obit_ff;
  logic        half_ff;
  logic        latch_ff;
  logic        busy_ff;
  logic [7:0]  pbuf [256];
  logic [255:0] vmask_ff;

  wire logic is_qpage = (cmd_ff == `SFPW_OP_QPAGE);
  wire logic is_prog  = (cmd_ff == `SFPW_OP_PAGE) | is_qpage;
  wire logic is_sect  = (cmd_ff == `SFPW_OP_SECT);
  wire logic is_hblk  = (cmd_ff == `SFPW_OP_HBLK);
  wire logic is_blk   = (cmd_ff == `SFPW_OP_BLK);
  wire logic is_erase = is_sect | is_hblk | is_blk;
  wire logic is_qread = (cmd_ff == `SFPW_OP_QREAD);
  wire logic is_stat  = (cmd_ff == `SFPW_OP_STAT1) |
                        (cmd_ff == `SFPW_OP_STAT2);
  wire logic quad_step = (is_qpage & (cnt_ff >= `SFPW_ADDR_END)) |
                         (is_qread & (cnt_ff >= `SFPW_CMD_BITS));
  wire logic [23:0] nxt_sh = quad_step ? {sh_ff[19:0], pin_s.io}
                                       : {sh_ff[22:0], pin_s.io[0]};
  wire logic [5:0] nxt_cnt = (cnt_ff >= `SFPW_QRD_DATA) ? cnt_ff :
                             6'(cnt_ff + (quad_step ? 6'h04 : 6'h01));
  wire logic got_cmd  = bit_rise & (cnt_ff < `SFPW_CMD_BITS) &
                        (nxt_cnt == `SFPW_CMD_BITS);
  wire logic got_addr = bit_rise & (cnt_ff < `SFPW_ADDR_END) &
                        (nxt_cnt == `SFPW_ADDR_END);
  wire logic in_data  = is_prog & (cnt_ff >= `SFPW_ADDR_END) & ~busy_ff;
  wire logic [2:0] nxt_dcnt = 3'(dcnt_ff + (quad_step ? 3'h4 : 3'h1));
  wire logic byte_done = in_data & bit_rise & (nxt_dcnt == 3'h0);

  // ----------------------------------------------------------------
  // command acceptance at deselect
  // ----------------------------------------------------------------
  wire logic prot_hit = guarded(addr_ff, region_guard_bits);
  wire logic may_run  = latch_ff & ~busy_ff;
  wire logic prog_go  = cs_rise & is_prog & may_run & any_ff &
                        (dcnt_ff == 3'h0) & ~prot_hit &
                        (~is_qpage | quad_io_enable);
  wire logic erase_go = cs_rise & is_erase & may_run &
                        (cnt_ff == `SFPW_ADDR_END) & ~prot_hit;
  wire logic run_go   = prog_go | erase_go;
  wire logic cmd_only = cs_rise & ~busy_ff & (cnt_ff == `SFPW_CMD_BITS);
  wire logic unlock_go = cmd_only & (cmd_ff == `SFPW_OP_UNLOCK);
  wire logic lock_go   = cmd_only & (cmd_ff == `SFPW_OP_LOCK);
  wire logic wrap_go   = cs_rise & ~busy_ff & (cmd_ff == `SFPW_OP_WRAP) &
                         (cnt_ff == `SFPW_WRAP_END);

  // whole-region base and size for the three erase kinds
  wire sfpw_pkg::sfpw_size_t er_size = is_sect ? sfpw_pkg::SFPW_SZ_4K :
                                        is_hblk ? sfpw_pkg::SFPW_SZ_32K :
                                                  sfpw_pkg::SFPW_SZ_64K;
  wire logic [4:0] er_bits = is_sect ? 5'(`SFPW_SECT_BITS) :
                             is_hblk ? 5'(`SFPW_HBLK_BITS) :
                                       5'(`SFPW_BLK_BITS);
  wire logic [23:0] er_base = addr_ff & ~24'((24'h000001 << er_bits) -
                                             24'h000001);
  wire logic [31:0] er_cyc = is_sect ? 32'(SECT_CYC - 1) :
                             is_hblk ? 32'(HBLK_CYC - 1) :
                                       32'(BLK_CYC - 1);

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sclk_d_ff <= 1'b0;
      sel_d_ff  <= 1'b0;
      cmd_ff    <= 8'h00;
      cnt_ff    <= 6'h00;
      sh_ff     <= 24'h000000;
      addr_ff   <= 24'h000000;
      dcnt_ff   <= 3'h0;
      col_ff    <= 8'h00;
      any_ff    <= 1'b0;
    end
    else
    begin
      sclk_d_ff <= pin_s.sclk;
      sel_d_ff  <= sel;
      if (cs_fall)
      begin
        cnt_ff  <= 6'h00;
        dcnt_ff <= 3'h0;
        any_ff  <= 1'b0;
        cmd_ff  <= 8'h00;
      end
      else if (bit_rise)
      begin
        sh_ff  <= nxt_sh;
        cnt_ff <= nxt_cnt;
        if (got_cmd)
          cmd_ff <= nxt_sh[7:0];
        // page address stays put while a cycle scans it
        if (got_addr & ~busy_ff)
        begin
          addr_ff <= nxt_sh;
          col_ff  <= nxt_sh[7:0];
        end
        if (in_data)
          dcnt_ff <= nxt_dcnt;
        if (byte_done)
        begin
          col_ff <= 8'(col_ff + 8'h01);
          any_ff <= 1'b1;
        end
      end
    end
  end

  // later bytes on the same column replace earlier ones
  always_ff @(posedge mclk)
  begin
    if (byte_done)
      pbuf[col_ff] <= nxt_sh[7:0];
  end

  always_ff @(posedge mclk)
  begin
    // status polls during a cycle must not clear the mask being scanned
    if (srst | (cs_fall & ~busy_ff))
      vmask_ff <= '0;
    else if (byte_done)
      vmask_ff[col_ff] <= 1'b1;
  end

  // ----------------------------------------------------------------
  // latch and wrap setting
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      latch_ff <= 1'b0;
      wrap_cfg <= `SFPW_WRAP_RST;
    end
    else
    begin
      if (run_go | lock_go)
        latch_ff <= 1'b0;
      else if (unlock_go)
        latch_ff <= 1'b1;
      if (wrap_go)
        wrap_cfg <= sh_ff[7:0];
    end
  end

  // ----------------------------------------------------------------
  // self-timed cycle: scan page buffer into the array queue
  // ----------------------------------------------------------------
  sfpw_pkg::sfpw_cyc_t     cyc_ff;
  sfpw_pkg::sfpw_arr_req_t ereq_ff;
  logic [7:0]  scol_ff;
  logic        er_ff;
  logic [31:0] tmr_ff;
  logic        q_ready;
  logic        q_idle;

  wire logic scan = (cyc_ff == sfpw_pkg::SFPW_C_SCAN);
  wire logic q_valid = scan & (er_ff | vmask_ff[scol_ff]);
  wire sfpw_pkg::sfpw_arr_req_t preq =
    '{size: sfpw_pkg::SFPW_SZ_BYTE,
      addr: {addr_ff[23:8], scol_ff},
      data: pbuf[scol_ff]};
  wire logic adv = scan & (q_ready | (~er_ff & ~vmask_ff[scol_ff]));
  wire logic done = (cyc_ff == sfpw_pkg::SFPW_C_WAIT) &
                    (tmr_ff == 32'h0) & q_idle;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cyc_ff  <= sfpw_pkg::SFPW_C_IDLE;
      busy_ff <= 1'b0;
      er_ff   <= 1'b0;
      scol_ff <= 8'h00;
      tmr_ff  <= 32'h0;
      ereq_ff <= '0;
    end
    else
    begin
      if (tmr_ff != 32'h0)
        tmr_ff <= tmr_ff - 32'h1;
      unique case (cyc_ff)
        sfpw_pkg::SFPW_C_IDLE:
          if (run_go)
          begin
            cyc_ff  <= sfpw_pkg::SFPW_C_SCAN;
            busy_ff <= 1'b1;
            er_ff   <= erase_go;
            scol_ff <= 8'h00;
            tmr_ff  <= prog_go ? 32'(PAGE_CYC - 1) : er_cyc;
            ereq_ff <= '{size: er_size, addr: er_base,
                         data: `SFPW_ERASED};
          end
        sfpw_pkg::SFPW_C_SCAN:
          if (adv)
          begin
            scol_ff <= 8'(scol_ff + 8'h01);
            if (er_ff | (scol_ff == `SFPW_LAST_COL))
              cyc_ff <= sfpw_pkg::SFPW_C_WAIT;
          end
        sfpw_pkg::SFPW_C_WAIT:
          if (done)
          begin
            cyc_ff  <= sfpw_pkg::SFPW_C_IDLE;
            busy_ff <= 1'b0;
          end
        default:
          cyc_ff <= sfpw_pkg::SFPW_C_IDLE;
      endcase
    end
  end

  sfpw_fifo #(.W($bits(sfpw_pkg::sfpw_arr_req_t)), .D(4)) u_fifo (
    .mclk      (mclk),
    .srst      (srst),
    .in_valid  (q_valid),
    .in_ready  (q_ready),
    .in_data   (er_ff ? ereq_ff : preq),
    .out_valid (arr_valid),
    .out_ready (arr_ready),
    .out_data  (arr_req),
    .idle      (q_idle)
  );

  // ----------------------------------------------------------------
  // outputs on falling serial clock: status and quad read
  // ----------------------------------------------------------------
  wire logic st_on = is_stat & (cnt_ff >= `SFPW_CMD_BITS);
  wire logic rd_on = is_qread & quad_io_enable & ~busy_ff &
                     (cnt_ff == `SFPW_QRD_DATA);
  wire logic [7:0] stat_byte = (cmd_ff == `SFPW_OP_STAT1) ?
    {1'b0, region_guard_bits, latch_ff, busy_ff} :
    {6'h00, quad_io_enable, 1'b0};

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      io_out      <= 4'h0;
      io_oe_n     <= `SFPW_OE_ALL_OFF;
      obit_ff     <= 3'h0;
      half_ff     <= 1'b0;
      mem_rd_addr <= 24'h000000;
    end
    else if (cs_fall | cs_rise)
    begin
      io_oe_n <= `SFPW_OE_ALL_OFF;
      obit_ff <= 3'h0;
      half_ff <= 1'b0;
    end
    else
    begin
      if (got_addr & is_qread)
        mem_rd_addr <= nxt_sh;
      if (bit_fall & st_on)
      begin
        io_oe_n   <= `SFPW_OE_SO_ONLY;
        io_out[1] <= stat_byte[3'h7 - obit_ff];
        obit_ff   <= 3'(obit_ff + 3'h1);
      end
      else if (bit_fall & rd_on)
      begin
        io_oe_n <= 4'h0;
        io_out  <= half_ff ? mem_rd_data[3:0] : mem_rd_data[7:4];
        half_ff <= ~half_ff;
        if (half_ff)
          mem_rd_addr <= next_rd(mem_rd_addr, wrap_cfg);
      end
    end
  end

  assign cycle_busy_flag  = busy_ff;
  assign write_latch_flag = latch_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence seq_hold_busy;
    cycle_busy_flag [*3];
  endsequence

  chk_busy_on_start: assert property (run_go |=> seq_hold_busy)
    else $error("busy not held after cycle start");
  chk_latch_drop: assert property ($rose(busy_ff) |-> !latch_ff)
    else $error("write latch still set in timed cycle");
  chk_needs_latch: assert property ($rose(busy_ff) |-> $past(latch_ff))
    else $error("cycle started without write latch");
  chk_prog_whole: assert property ($rose(busy_ff) && !er_ff |->
    $past(dcnt_ff) == 3'h0 && $past(any_ff))
    else $error("program accepted on partial byte");
  chk_erase_exact: assert property ($rose(busy_ff) && er_ff |->
    $past(cnt_ff) == 6'h20)
    else $error("erase accepted with wrong bit count");
  chk_quad_gate: assert property ($rose(busy_ff) && $past(is_qpage) |->
    $past(quad_io_enable))
    else $error("quad program without quad enable");
  chk_guard_hit: assert property ($rose(busy_ff) |-> !$past(prot_hit))
    else $error("cycle started on guarded region");
  chk_col_wrap: assert property (byte_done && col_ff == 8'hFF |=>
    col_ff == 8'h00)
    else $error("page column did not wrap");
  chk_rd_section: assert property (bit_fall && rd_on && half_ff &&
    !wrap_cfg[4] |=> mem_rd_addr[23:6] == $past(mem_rd_addr[23:6]))
    else $error("wrapped read left its section");
  chk_busy_end: assert property ($fell(busy_ff) |-> $past(q_idle) &&
    $past(tmr_ff) == 32'h0)
    else $error("busy dropped before cycle finished");
endmodule // sfpw_core

// *** sfpw_host.sv ***
/*
  Host model: drives select, serial clock and io lanes in mode 0.
  Assumes mclk at 50 MHz; one serial clock spans eight mclk periods.
*/
`timescale 1ns/1ns
module sfpw_host (
  input  wire logic           mclk,
  input  wire logic [3:0]     io_out,
  input  wire logic [3:0]     io_oe_n,
  output sfpw_pkg::sfpw_pin_t pin
);
  // ------------------------------------------------------------
  // wire levels and frame tasks
  // ------------------------------------------------------------
  logic       cs_n;
  logic       sclk;
  logic [3:0] drv;
  logic [3:0] io_w;
  logic [7:0] rx;
  logic [3:0] nb;

  // a lane shows the device only where it has its driver on
  assign io_w = (io_oe_n & drv) | (~io_oe_n & io_out);
  assign pin  = {cs_n, sclk, io_w};

  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    drv  = 4'h0;
    rx   = 8'h00;
  end

  // pins move 2 ns after an mclk edge, four edges per half clock
  task half();
    repeat (4) @(posedge mclk);
    #2;
  endtask

  task clk1(input logic [3:0] d);
    drv  = d;
    half();
    sclk = 1'b1;
    half();
    rx   = {rx[6:0], io_w[1]};
    nb   = io_w;
    sclk = 1'b0;
  endtask

  // spare lanes flip every clock so they never look settled
  task nib(input logic [3:0] v, input logic quad);
    if (quad)
      clk1(v);
    else
      for (int i = 3; i >= 0; i--)
        clk1({~drv[3:1], v[i]});
  endtask

  task byte8(input logic [7:0] v, input logic quad);
    nib(v[7:4], quad);
    nib(v[3:0], quad);
  endtask

  task sel();
    cs_n = 1'b0;
    half();
  endtask

  task desel();
    half();
    cs_n = 1'b1;
    drv  = ~drv;
    half();
    half();
  endtask

  task stat(input logic [7:0] op, output logic [7:0] s);
    sel();
    byte8(op, 1'b0);
    byte8(8'h00, 1'b0);
    s = rx;
    desel();
  endtask
endmodule // sfpw_host

// *** tb_sfpw_core.sv ***
/*
  Self-checking bench of the flash sequencer: host frames, array sink.
  Assumes shortened cycle counts; the array stalls every other edge.
*/
`timescale 1ns/1ns
module tb_sfpw_core;
  logic                    mclk;
  logic                    srst;
  logic                    quad_io_enable;
  logic [4:0]              region_guard_bits;
  logic                    arr_ready;
  logic                    arr_valid;
  logic                    cycle_busy_flag;
  logic                    write_latch_flag;
  logic [7:0]              wrap_cfg;
  logic [23:0]             mem_rd_addr;
  logic [3:0]              io_out;
  logic [3:0]              io_oe_n;
  sfpw_pkg::sfpw_pin_t     pin;
  sfpw_pkg::sfpw_arr_req_t arr_req;
  logic [33:0]             q[$];
  logic [7:0]              s;
  logic [7:0]              ops[4] = '{8'h00, 8'h20, 8'h52, 8'hD8};
  int                      sh[4] = '{0, 12, 15, 16};
  logic [7:0]              wset[5] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h10};
  int                      n_fail = 0;
  int                      checked = 0;
  int                      cyc = 0;

  sfpw_core #(.PAGE_CYC(60), .SECT_CYC(80), .HBLK_CYC(90), .BLK_CYC(100))
  sfpw_core_i (.mclk(mclk), .srst(srst), .pin_i(pin), .io_out(io_out),
    .io_oe_n(io_oe_n), .quad_io_enable(quad_io_enable),
    .region_guard_bits(region_guard_bits),
    .cycle_busy_flag(cycle_busy_flag), .write_latch_flag(write_latch_flag),
    .wrap_cfg(wrap_cfg), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_addr[7:0] ^ 8'h3C), .arr_valid(arr_valid),
    .arr_ready(arr_ready), .arr_req(arr_req));

  sfpw_host sfpw_host_i (.mclk(mclk), .io_out(io_out), .io_oe_n(io_oe_n),
    .pin(pin));

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  // ------------------------------------------------------------
  // array sink, cycle ceiling, helpers
  // ------------------------------------------------------------
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (arr_valid === 1'b1 && arr_ready === 1'b1)
      q.push_back(arr_req);
    #2;
    arr_ready = ~arr_ready;
    if (cyc == 60000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  task wrap_up();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [33:0] seen, input logic [33:0] e);
    checked++;
    if (seen !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", nm, e, seen);
    end
  endtask

  task pop(input logic [33:0] e);
    logic [33:0] v;
    v = 'x;
    if (q.size() > 0)
      v = q.pop_front();
    chk("arr_req", v, e);
  endtask

  task frm(input logic [7:0] op, input logic [23:0] a, input int n,
           input logic [7:0] b, input logic quad, input logic cut);
    sfpw_host_i.sel();
    sfpw_host_i.byte8(op, 1'b0);
    for (int i = 2; i >= 0; i--)
      sfpw_host_i.byte8(a[i*8 +: 8], 1'b0);
    for (int i = 0; i < n; i++)
      sfpw_host_i.byte8(8'(b + i + (i >> 8)), quad);
    if (cut)
      sfpw_host_i.nib(4'h5, 1'b0);
    sfpw_host_i.desel();
  endtask

  task unlock();
    sfpw_host_i.sel();
    sfpw_host_i.byte8(8'h06, 1'b0);
    sfpw_host_i.desel();
  endtask

  task idle_wait();
    s = 8'hFF;
    for (int i = 0; i < 20 && s[0] !== 1'b0; i++)
      sfpw_host_i.stat(8'h05, s);
    chk("idle", s[0], 1'b0);
  endtask

  // quad read of ten bytes; k picks 8<<k byte sections, 4 means no wrap
  task qread(input logic [23:0] a, input int k);
    logic [7:0] m;
    logic [7:0] e;
    m = (k == 4) ? 8'hFF : 8'((8 << k) - 1);
    sfpw_host_i.sel();
    sfpw_host_i.byte8(8'hEB, 1'b0);
    for (int i = 2; i >= 0; i--)
      sfpw_host_i.byte8(a[i*8 +: 8], 1'b1);
    sfpw_host_i.byte8(8'h00, 1'b1);
    repeat (4)
      sfpw_host_i.clk1(4'h0);
    for (int j = 0; j < 10; j++)
    begin
      sfpw_host_i.clk1(4'h0);
      s[7:4] = sfpw_host_i.nb;
      sfpw_host_i.clk1(4'h0);
      s[3:0] = sfpw_host_i.nb;
      e = (a[7:0] & ~m) | (8'(a[7:0] + j) & m);
      chk("qread", s, e ^ 8'h3C);
    end
    sfpw_host_i.desel();
  endtask

  initial
  begin
    srst = 1'b1;
    arr_ready = 1'b0;
    quad_io_enable = 1'b0;
    region_guard_bits = 5'h00;
    repeat (3) @(posedge mclk);
    #2;
    srst = 1'b0;
    repeat (4) @(posedge mclk);
    #2;
    chk("reset", {cycle_busy_flag, write_latch_flag, wrap_cfg}, 10'h10);
    frm(8'h02, 24'h0A00FE, 3, 8'h00, 1'b0, 1'b0);
    chk("locked", q.size() + cycle_busy_flag, 0);
    unlock();
    sfpw_host_i.stat(8'h05, s);
    chk("latch", s[1], 1'b1);
    frm(8'h02, 24'h0A00FE, 3, 8'h00, 1'b0, 1'b0);
    sfpw_host_i.stat(8'h05, s);
    chk("busy latch", s[1:0], 2'b01);
    idle_wait();
    pop({2'h0, 24'h0A0000, 8'h02});
    for (int i = 0; i < 2; i++)
      pop({2'h0, 16'h0A00, 8'(8'hFE + i), 8'(i)});
    unlock();
    frm(8'h02, 24'h0A0300, 1, 8'h00, 1'b0, 1'b1);
    chk("cut program", q.size() + cycle_busy_flag, 0);
    frm(8'h20, 24'h0A0300, 0, 8'h00, 1'b0, 1'b1);
    chk("cut erase", q.size() + cycle_busy_flag, 0);
    region_guard_bits = 5'h01;
    frm(8'hD8, 24'hFF1234, 0, 8'h00, 1'b0, 1'b0);
    frm(8'h02, 24'hFF0000, 1, 8'h00, 1'b0, 1'b0);
    chk("guarded", q.size() + cycle_busy_flag, 0);
    region_guard_bits = 5'h00;
    frm(8'h32, 24'h0B0010, 1, 8'h00, 1'b1, 1'b0);
    chk("quad off", q.size() + cycle_busy_flag, 0);
    sfpw_host_i.stat(8'h05, s);
    chk("kept", s[1:0], 2'b10);
    quad_io_enable = 1'b1;
    frm(8'h32, 24'h0B0010, 257, 8'h00, 1'b1, 1'b0);
    idle_wait();
    for (int c = 0; c < 256; c++)
      pop({2'h0, 16'h0B00, 8'(c), (8'(c - 16) == 8'h00) ? 8'h01
           : 8'(c - 16)});
    for (int k = 1; k < 4; k++)
    begin
      unlock();
      frm(ops[k], 24'h12B456, 0, 8'h00, 1'b0, 1'b0);
      idle_wait();
      pop({2'(k), (24'h12B456 >> sh[k]) << sh[k], 8'hFF});
    end
    for (int k = 0; k < 5; k++)
    begin
      frm(8'h77, 24'h000000, 1, wset[k], 1'b0, 1'b0);
      chk("wrap", wrap_cfg, wset[k]);
      qread(24'h01233D, k);
    end
    wrap_up();
  end
endmodule // tb_sfpw_core
